/* File: src/oneshot_cfg.svh */
/*
   Constants for the output timer enable and single-shot block: register
   indices and byte addresses, bit positions, reset values, count divider.
   Assumes a 32-bit APB byte address and the 50 MHz system clock.
*/
`ifndef ONESHOT_CFG_SVH
`define ONESHOT_CFG_SVH

// printed offsets are register indices; byte address is four times that
`define OS_IDX_PERMIT 32'h0080_02FA
`define OS_IDX_PROTECT 32'h0080_02FC
`define OS_IDX_RUN 32'h0080_02FE
`define OS_ADDR_PERMIT (`OS_IDX_PERMIT << 2)
`define OS_ADDR_PROTECT (`OS_IDX_PROTECT << 2)
`define OS_ADDR_RUN (`OS_IDX_RUN << 2)

// reload, interrupt status and interrupt mask registers
`define OS_ADDR_RELOAD0 32'h0200_1000
`define OS_ADDR_STATUS 32'h0200_1040
`define OS_ADDR_MASK 32'h0200_1044

// channel n sits at bit OS_BIT_TOP - n; bits below OS_BIT_LOW read zero
`define OS_NUM_CHAN 11
`define OS_BIT_TOP 15
`define OS_BIT_LOW 5

// reset values
`define OS_RST_CTRL 16'h0000
`define OS_RST_CNT 16'h0000

// count clock is sys_clk divided by this figure
`define OS_CNT_DIV 8'h04

`endif

/* File: src/oneshot_pkg.sv */
/*
   Types for the output timer enable and single-shot block.
   Assumes the constants header is included by the design file.
*/
package oneshot_pkg;

   // per-channel sequence: idle, waiting for count clock, counting
   typedef enum logic [1:0] {
      CH_IDLE,
      CH_ARMED,
      CH_COUNT
   } chState_t;

   // one decoded APB access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } busAccess_t;

endpackage

/* File: src/output_timer_enable_oneshot.sv */
/*
   Enable control and single-shot output for eleven 16-bit timer channels,
   with an APB register slave, reload registers and a masked interrupt.
   Assumes a single 50 MHz clock, synchronous reset, and external start
   pins that are asynchronous to the clock.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "oneshot_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01: permit bit gates each external start input
// RULE_02: channel n bit at position fifteen minus n
// RULE_03: low five bits read zero, ignore writes
// RULE_04: protect bit blocks software run bit writes
// RULE_05: unprotected write of one starts channel
// RULE_06: unprotected write of zero stops channel
// RULE_07: underflow clears run bit, shows status
// RULE_08: software uses halfword accesses only
// RULE_09: start by software or permitted external
// RULE_10: start copies reload into counter on tick
// RULE_11: decrement each count tick, halt at underflow
// RULE_12: output toggles at start and underflow
// RULE_13: underflow raises interrupt request
// RULE_14: start to underflow is reload plus one
// RULE_15: old counter value never affects operation
// RULE_16: external start also sets run bit
// RULE_17: underflow stop beats external start
// RULE_18: software enable beats underflow stop
// RULE_19: software stop beats external start
module output_timer_enable_oneshot (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external start pins, one per channel
   input wire logic [10:0] extStart,
   // timer outputs and interrupt
   output logic [10:0] timerOut,
   output logic irq
);

   localparam int NCH = `OS_NUM_CHAN;
   localparam logic [15:0] RST_CTRL = `OS_RST_CTRL;

   oneshot_pkg::busAccess_t acc;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic hitPermit, hitProtect, hitRun, hitStatus, hitMask, hitReload;
   logic [31:0] relOff;
   logic [3:0] relIdx;
   logic [31:0] rdData;
   logic mapped;
   logic [NCH-1:0] permit_q, protect_q, run_q, status_q, mask_q;
   logic [NCH-1:0] extSync1_q, extSync2_q, extPrev_q;
   logic [NCH-1:0] uflow, loadEv;
   logic [NCH-1:0] out_q;
   logic [15:0] permitView, protectView, runView, statusView, maskView;
   logic [15:0] reload_q [NCH];
   logic [15:0] cnt_q [NCH];
   logic [7:0] div_q;
   logic tick_q;
   logic irq_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   ///////////////////////////////////////////////////////////////////////////
   // apb decode

   // a write takes effect only in the access phase once pready is up
   always_comb begin
      acc.wr = psel && penable && pwrite && pready_q;
      acc.rd = psel && !penable && !pwrite;
      acc.addr = paddr;
      acc.wdata = pwdata;
   end

   always_comb begin
      hitPermit = (acc.addr == `OS_ADDR_PERMIT);
      hitProtect = (acc.addr == `OS_ADDR_PROTECT);
      hitRun = (acc.addr == `OS_ADDR_RUN);
      hitStatus = (acc.addr == `OS_ADDR_STATUS);
      hitMask = (acc.addr == `OS_ADDR_MASK);
      relOff = acc.addr - `OS_ADDR_RELOAD0;
      relIdx = relOff[5:2];
      hitReload = (relOff[31:6] == '0) && (relOff[1:0] == 2'b00)
         && (relIdx < 4'(NCH));
      mapped = hitPermit | hitProtect | hitRun | hitStatus | hitMask
         | hitReload;
   end

   // read mux; unmapped reads return zero with an error
   always_comb begin
      rdData = 32'h0000_0000;
      if (hitPermit) begin
         rdData[15:0] = permitView;
      end else if (hitProtect) begin
         rdData[15:0] = protectView;
      end else if (hitRun) begin
         rdData[15:0] = runView;
      end else if (hitStatus) begin
         rdData[15:0] = statusView;
      end else if (hitMask) begin
         rdData[15:0] = maskView;
      end else if (hitReload) begin
         rdData[15:0] = reload_q[relIdx];
      end
   end

   // one wait-free answer: pready rises for the access phase only
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !mapped;
         if (acc.rd) begin
            prdata_q <= rdData;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // count clock divider

   // one-cycle tick every OS_CNT_DIV sys_clk cycles
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == `OS_CNT_DIV - 8'h01);
         if (div_q == `OS_CNT_DIV - 8'h01) begin
            div_q <= 8'h00;
         end else begin
            div_q <= div_q + 8'h01;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // external start synchronisers

   // three flops per pin; only the second and later stages feed logic
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         extSync1_q <= '0;
         extSync2_q <= '0;
         extPrev_q <= '0;
      end else begin
         extSync1_q <= extStart;
         extSync2_q <= extSync1_q;
         extPrev_q <= extSync2_q;
      end
   end

   // unused low bits of every control view
   assign permitView[`OS_BIT_LOW-1:0] = '0; // RULE_03
   assign protectView[`OS_BIT_LOW-1:0] = '0; // RULE_03
   assign runView[`OS_BIT_LOW-1:0] = '0; // RULE_03
   assign statusView[`OS_BIT_LOW-1:0] = '0;
   assign maskView[`OS_BIT_LOW-1:0] = '0;

   ///////////////////////////////////////////////////////////////////////////
   // per-channel logic

   genvar n;
   generate
      for (n = 0; n < NCH; n++) begin : g_ch
         localparam int B = `OS_BIT_TOP - n;
         oneshot_pkg::chState_t st_q;
         logic extGo, swHit, runD, startEv;
         logic [16:0] width_q;
         logic [15:0] loaded_q;

         // register views place channel n at bit fifteen minus n
         assign permitView[B] = permit_q[n]; // RULE_02
         assign protectView[B] = protect_q[n]; // RULE_02
         assign runView[B] = run_q[n]; // RULE_02
         assign statusView[B] = status_q[n];
         assign maskView[B] = mask_q[n];

         assign extGo = extSync2_q[n] && !extPrev_q[n] && permit_q[n]; // RULE_01
         assign swHit = acc.wr && hitRun && !protect_q[n]; // RULE_04
         assign uflow[n] = tick_q && (st_q == oneshot_pkg::CH_COUNT)
            && (cnt_q[n] == 16'h0000); // RULE_11 RULE_14
         assign loadEv[n] = tick_q && (st_q == oneshot_pkg::CH_ARMED) && runD;

         // later lines win: software over underflow over external start
         always_comb begin
            runD = run_q[n];
            if (extGo) begin
               runD = 1'b1; // RULE_09 RULE_16
            end
            if (uflow[n]) begin
               runD = 1'b0; // RULE_07 RULE_17
            end
            if (swHit) begin
               runD = acc.wdata[B]; // RULE_05 RULE_06 RULE_18 RULE_19
            end
         end
         assign startEv = runD && (!run_q[n] || uflow[n]);

         // control registers written over the bus
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               permit_q[n] <= RST_CTRL[B];
               protect_q[n] <= RST_CTRL[B];
               mask_q[n] <= 1'b0;
            end else if (acc.wr) begin
               if (hitPermit) begin
                  permit_q[n] <= acc.wdata[B];
               end
               if (hitProtect) begin
                  protect_q[n] <= acc.wdata[B];
               end
               if (hitMask) begin
                  mask_q[n] <= acc.wdata[B];
               end
            end
         end

         // run bit doubles as the running status
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               run_q[n] <= RST_CTRL[B];
            end else begin
               run_q[n] <= runD;
            end
         end

         // reload value; takes effect only at the next start
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               reload_q[n] <= `OS_RST_CNT;
            end else if (acc.wr && hitReload && relIdx == 4'(n)) begin
               reload_q[n] <= acc.wdata[15:0];
            end
         end

         // sequence and down counter
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               st_q <= oneshot_pkg::CH_IDLE;
               cnt_q[n] <= `OS_RST_CNT;
            end else begin
               case (st_q)
                  oneshot_pkg::CH_IDLE: begin
                     if (startEv) begin
                        st_q <= oneshot_pkg::CH_ARMED;
                     end
                  end
                  oneshot_pkg::CH_ARMED: begin
                     if (!runD) begin
                        st_q <= oneshot_pkg::CH_IDLE;
                     end else if (tick_q) begin
                        cnt_q[n] <= reload_q[n]; // RULE_10 RULE_15
                        st_q <= oneshot_pkg::CH_COUNT;
                     end
                  end
                  oneshot_pkg::CH_COUNT: begin
                     if (startEv) begin
                        st_q <= oneshot_pkg::CH_ARMED;
                     end else if (!runD || uflow[n]) begin
                        st_q <= oneshot_pkg::CH_IDLE; // RULE_11
                     end else if (tick_q) begin
                        cnt_q[n] <= cnt_q[n] - 16'h0001; // RULE_11
                     end
                  end
                  default: begin
                     st_q <= oneshot_pkg::CH_IDLE;
                  end
               endcase
            end
         end

         // one pulse: invert at load and at underflow
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               out_q[n] <= 1'b0;
            end else if (loadEv[n] || uflow[n]) begin
               out_q[n] <= ~out_q[n]; // RULE_12
            end
         end

         // sticky flag; a new underflow beats a clear in the same cycle
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               status_q[n] <= 1'b0;
            end else if (uflow[n]) begin
               status_q[n] <= 1'b1; // RULE_13
            end else if (acc.wr && hitStatus && acc.wdata[B]) begin
               status_q[n] <= 1'b0;
            end
         end

         // checker helper: count ticks from load to underflow
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               width_q <= 17'h0_0000;
               loaded_q <= 16'h0000;
            end else if (loadEv[n]) begin
               width_q <= 17'h0_0001;
               loaded_q <= reload_q[n];
            end else if (tick_q && st_q == oneshot_pkg::CH_COUNT) begin
               width_q <= width_q + 17'h0_0001;
            end
         end

         chk_protect_blocks: assert property ( // RULE_04
            acc.wr && hitRun && protect_q[n] && !extGo && !uflow[n]
            |=> run_q[n] == $past(run_q[n]))
            else $error("protected run bit changed");
         chk_sw_start: assert property ( // RULE_05
            swHit && acc.wdata[B] |=> run_q[n])
            else $error("software start lost");
         chk_sw_stop: assert property ( // RULE_06
            swHit && !acc.wdata[B] |=> !run_q[n])
            else $error("software stop lost");
         chk_uflow_clear: assert property ( // RULE_07
            uflow[n] && !swHit |=> !run_q[n] && !timerOut[n] == $past(out_q[n])
            )
            else $error("underflow did not stop channel");
         chk_ext_gated: assert property ( // RULE_01
            extSync2_q[n] && !extPrev_q[n] && !permit_q[n] && !run_q[n]
            && !swHit |=> !run_q[n])
            else $error("forbidden external start taken");
         chk_load_reload: assert property ( // RULE_10
            loadEv[n] |=> cnt_q[n] == $past(reload_q[n])
            ##1 out_q[n] != $past(out_q[n], 2))
            else $error("reload not loaded at start");
         chk_pulse_width: assert property ( // RULE_14
            uflow[n] |-> width_q == {1'b0, loaded_q} + 17'h0_0001)
            else $error("pulse width not reload plus one");
         chk_irq_flag: assert property ( // RULE_13
            uflow[n] |=> status_q[n] ##1 (irq || !$past(mask_q[n])))
            else $error("underflow flag or interrupt missing");
      end
   endgenerate

   ///////////////////////////////////////////////////////////////////////////
   // interrupt and outputs

   // level interrupt while any unmasked flag stands
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign timerOut = out_q;
   assign irq = irq_q;

   chk_reserved_zero: assert property ( // RULE_03
      acc.rd && (hitPermit || hitProtect || hitRun)
      |=> prdata[4:0] == 5'h00)
      else $error("reserved bits read nonzero");
   chk_irq_level: assert property ( // RULE_13
      irq == $past(|(status_q & mask_q)))
      else $error("interrupt level wrong");
   chk_apb_ready: assert property (
      psel && !penable |=> pready ##1 !pready || (psel && !penable))
      else $error("ready not in access phase");

   cov_uflow: cover property (uflow[0] ##1 irq);
   cov_ext_start: cover property (g_ch[1].extGo ##[1:8] loadEv[1]);
   cov_sw_vs_uflow: cover property (uflow[2] && g_ch[2].swHit);
   cov_pulse: cover property (loadEv[3] ##[1:300] uflow[3]);

endmodule

/* File: verif/testbench.sv */
/*
   Self-checking bench for the timer enable and single-shot block.
   Assumes the design's APB slave and constants header as delivered.
*/
`timescale 1ns/10ps
`include "oneshot_cfg.svh"

module testbench;
   localparam logic [31:0] A_PERM = `OS_ADDR_PERMIT;
   localparam logic [31:0] A_PROT = `OS_ADDR_PROTECT;
   localparam logic [31:0] A_RUN = `OS_ADDR_RUN;
   localparam logic [31:0] A_RL = `OS_ADDR_RELOAD0;
   localparam logic [31:0] A_ST = `OS_ADDR_STATUS;
   logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, irq;
   logic [31:0] paddr, pwdata, prdata;
   logic [10:0] extStart, timerOut;
   logic [10:0] outPrev = '0;
   // expected reads as {slverr, data}; expected pulse widths per channel
   logic [32:0] expRd[$];
   int unsigned expW[11][$];
   int unsigned riseAt[11];
   int unsigned cyc = 0;
   int unsigned seedVal;
   int nErrors;
   int cmpCount;

   output_timer_enable_oneshot dut (
      .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extStart(extStart),
      .timerOut(timerOut), .irq(irq));

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   ///////////////////////////////////////////////////////////////////////////
   // comparison and closing
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nErrors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ///////////////////////////////////////////////////////////////////////////
   // apb master; request held until pready is seen, idle cycle after
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no wait-state count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic regWrite(input logic [31:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d});
   endtask

   // note the expected answer, the monitor compares it
   task automatic regRead(input logic [31:0] a, input logic [15:0] d,
                          input logic err = 1'b0);
      expRd.push_back({err, 16'h0000, d});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // read monitor: oldest note against each completed read
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
         check({pslverr, prdata}, expRd.size() ? expRd.pop_front() : 'x);
      end
   end

   // pulse monitor: width in sys_clk cycles from rise to fall
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      outPrev <= timerOut;
      for (int c = 0; c < 11; c++) begin
         if (srst === 1'b0 && timerOut[c] !== outPrev[c]) begin
            if (timerOut[c] === 1'b1) begin
               riseAt[c] = cyc;
            end else begin
               check(cyc - riseAt[c], expW[c].size() ? expW[c].pop_front()
                                                     : 'x);
            end
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // bounded wait for one whole pulse of a channel
   task automatic waitPulse(input int c);
      int n;
      n = 0;
      while (timerOut[c] !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      check(timerOut[c], 1'b1);
      while (timerOut[c] !== 1'b0 && n < 4000) begin
         @(posedge sys_clk);
         n++;
      end
      check(timerOut[c], 1'b0);
      repeat (3) @(posedge sys_clk);
   endtask

   // software single shot; width is reload plus one count ticks
   task automatic shot(input int c, input logic [15:0] r);
      regWrite(A_RL + 32'(4 * c), r);
      expW[c].push_back((32'(r) + 1) * `OS_CNT_DIV);
      regWrite(A_RUN, 16'h8000 >> c);
      regRead(A_RUN, 16'h8000 >> c);
      waitPulse(c);
      regRead(A_RUN, 16'h0000);
   endtask

   // pin held long enough to pass the synchroniser
   task automatic extPulse(input int c);
      extStart[c] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      extStart[c] <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   ///////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      nErrors = 0;
      cmpCount = 0;
      srst <= 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= '0;
      pwdata <= '0;
      extStart <= '0;
      seedVal = $urandom(32'hd3623f70);
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      // reset values, unmapped address refused
      regRead(A_PERM, 16'h0000);
      regRead(A_PROT, 16'h0000);
      regRead(A_RUN, 16'h0000);
      regRead(32'h0000_0100, 16'h0000, 1'b1);
      // unassigned low bits read zero and ignore writes
      regWrite(A_PERM, 16'hFFFF);
      regRead(A_PERM, 16'hFFE0);
      regWrite(A_PROT, 16'h401F);
      regRead(A_PROT, 16'h4000);
      regWrite(A_RUN, 16'h401F);
      regRead(A_RUN, 16'h0000);
      regWrite(A_PROT, 16'h0000);
      // interrupt: channel 0 unmasked, channel 1 masked out
      regWrite(A_ST + 4, 16'h8000);
      shot(0, 16'h0005);
      check(irq, 1'b1);
      shot(1, 16'h0002);
      regRead(A_ST, 16'hC000);
      regWrite(A_ST, 16'h8000);
      repeat (2) @(posedge sys_clk);
      check(irq, 1'b0);
      regRead(A_ST, 16'h4000);
      // every channel twice with new random reloads, reload 0 included
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 11; c++) begin
            shot(c, (p == 0 && c == 10) ? 16'h0000
                                        : 16'($urandom_range(1, 12)));
         end
      end
      // external start, refused then permitted
      regWrite(A_PERM, 16'h0000);
      extPulse(2);
      regRead(A_RUN, 16'h0000);
      regWrite(A_PERM, 16'h2000);
      regWrite(A_RL + 8, 16'h0004);
      expW[2].push_back(5 * `OS_CNT_DIV);
      extPulse(2);
      regRead(A_RUN, 16'h2000);
      waitPulse(2);
      regRead(A_RUN, 16'h0000);
      // protected stop ignored, unprotected stop takes effect
      regWrite(A_ST, 16'hFFE0);
      regWrite(A_RL + 12, 16'h00C8);
      regWrite(A_RUN, 16'h1000);
      regWrite(A_PROT, 16'h1000);
      regWrite(A_RUN, 16'h0000);
      regRead(A_RUN, 16'h1000);
      regWrite(A_PROT, 16'h0000);
      regWrite(A_RUN, 16'h0000);
      regRead(A_RUN, 16'h0000);
      repeat (900) @(posedge sys_clk);
      regRead(A_ST, 16'h0000);
      for (int c = 0; c < 11; c++) begin
         check(expW[c].size(), 0);
      end
      report_and_stop();
   end

   // watchdog well past the expected run length
   initial begin
      repeat (30000) @(posedge sys_clk);
      nErrors++;
      report_and_stop();
   end
endmodule
